// File: shared/sdc_regs.svh
// Register constants for the start-up sensing and dead-time configuration block.
// Assumes the register port of the device addresses registers by an 8-bit index.
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// ----------------------------------------------------------------------------
// Register location and reset
// ----------------------------------------------------------------------------
`define SDC_CFG_ADDR 8'h96
`define SDC_CFG_RESET 16'h0000
`define SDC_CFG_WMASK 16'hff7f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SDC_ANGLE_MSB 15
`define SDC_ANGLE_LSB 14
`define SDC_THR_MSB 13
`define SDC_THR_LSB 10
`define SDC_RATE_MSB 9
`define SDC_RATE_LSB 8
`define SDC_RSVD_BIT 7
`define SDC_GAIN_MSB 6
`define SDC_GAIN_LSB 5
`define SDC_GAP_MSB 4
`define SDC_GAP_LSB 0

// ----------------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------------
`define SDC_CLK_NS 25
`define SDC_GAP_STEP_NS 40
`define SDC_ALIGN_CYCLES 16'h0010

`endif

// File: shared/sdc_pkg.sv
// Types for the start-up sensing and dead-time configuration block.
// Assumes sdc_regs.svh holds the numeric constants.
package sdc_pkg;

    // ------------------------------------------------------------------------
    // Start-up sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SDC_IDLE,
        SDC_SENSE,
        SDC_ALIGN,
        SDC_RUN
    } sdc_state_t;

endpackage : sdc_pkg

// File: hw/sdc_gap_timer.sv
// Dead-time timer: counts out one driver gap after each request.
// Assumes one 40 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "sdc_regs.svh"

module sdc_gap_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request and length in cycles
    input wire logic start,
    input wire logic [10:0] len,
    // Gap still running
    output logic busy
);

    typedef struct packed {
        logic [10:0] cnt;
        logic busy;
    } sdc_gap_st_t;

    sdc_gap_st_t st_reg;
    sdc_gap_st_t st_next;

    // ------------------------------------------------------------------------
    // Countdown; a new start restarts the gap
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        if (start)
        begin
            st_next.cnt = len;
            st_next.busy = 1'b1;
        end
        else if (st_reg.busy)
        begin
            if (st_reg.cnt <= 11'h001)
            begin
                st_next.busy = 1'b0;
                st_next.cnt = 11'h000;
            end
            else
            begin
                st_next.cnt = st_reg.cnt - 11'h001;
            end
        end
    end

    // Register the state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.busy;

endmodule : sdc_gap_timer

// File: hw/sdc_config.sv
// Configuration register with start-up sensing, advance, loop gain and
// driver gap decode. Assumes the device register port gives a one-cycle
// write strobe and an address index, both synchronous to CLK.
`timescale 1ns/1ps
`include "sdc_regs.svh"

// Operation
// - Angle code selects 30/60/90/120 degree advance.
// - Threshold zero skips sensing; align then accelerate.
// - Code zero 0 A; code one 0.4 A; codes 2 to 15 0.2 A times n+1.
// - Rate code gives 12/24/47/95 Hz sensing pulses.
// - Rate code gives 2.56 to 0.32 us resolution.
// - Gap time is (n+1) times 40 ns.
// - Gain code gives 0.25/0.5/0.75/1.
// - Register at 0x96, reset clears all fields.
module sdc_config (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [15:0] WDATA,
    output logic [15:0] RDATA,
    // Start-up request and gap request
    input wire logic START,
    input wire logic GAP_REQ,
    // Decoded parameters
    output logic [6:0] ADVANCE_DEG,
    output logic [5:0] THRESH_DA,
    output logic [6:0] SENSE_RATE_HZ,
    output logic [8:0] SENSE_RES_NS10,
    output logic [6:0] GAIN_PCT,
    output logic [10:0] GAP_NS,
    output logic SENSE_EN,
    output logic ALIGN_ACTIVE,
    output logic GAP_ACTIVE
);

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] rdata;
        sdc_pkg::sdc_state_t state;
        logic [15:0] cnt;
        logic [6:0] adv;
        logic [5:0] thr;
        logic [6:0] rate;
        logic [8:0] res;
        logic [6:0] gain;
        logic [10:0] gap;
        logic sense;
        logic align;
    } sdc_st_t;

    sdc_st_t st_reg;
    sdc_st_t st_next;
    logic gap_busy;

    // ------------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------------
    // Threshold in tenths of an ampere; code 15 gives 3.2 A, so six bits are needed
    function automatic logic [5:0] thr_da(input logic [3:0] code);
        logic [5:0] v;
        v = 6'h00;
        if (code == 4'h1)
        begin
            v = 6'h04;
        end
        else if (code != 4'h0)
        begin
            v = {1'b0, code, 1'b0} + 6'h02;
        end
        return v;
    endfunction : thr_da

    // Gap in ns, (n+1) steps of 40 ns
    function automatic logic [10:0] gap_ns(input logic [4:0] code);
        return 11'((11'(code) + 11'h001) * 11'(`SDC_GAP_STEP_NS));
    endfunction : gap_ns

    // ------------------------------------------------------------------------
    // Register access, decode and start-up sequencer
    // ------------------------------------------------------------------------
    always_comb
    begin
        logic [15:0] c;
        c = st_reg.cfg;
        st_next = st_reg;
        if (WR_EN && ADDR == `SDC_CFG_ADDR)
        begin
            // Bit 7 is kept at zero whatever the host sends
            c = WDATA & `SDC_CFG_WMASK;
        end
        st_next.cfg = c;
        if (RD_EN && ADDR == `SDC_CFG_ADDR)
        begin
            st_next.rdata = st_reg.cfg;
        end
        else if (RD_EN)
        begin
            st_next.rdata = 16'h0000;
        end
        // Decodes follow the value being stored, and change on the same edge as cfg
        case (c[`SDC_ANGLE_MSB:`SDC_ANGLE_LSB])
            2'h0: st_next.adv = 7'h1e;
            2'h1: st_next.adv = 7'h3c;
            2'h2: st_next.adv = 7'h5a;
            default: st_next.adv = 7'h78;
        endcase
        case (c[`SDC_RATE_MSB:`SDC_RATE_LSB])
            2'h0:
            begin
                st_next.rate = 7'h0c;
                st_next.res = 9'h100;
            end
            2'h1:
            begin
                st_next.rate = 7'h18;
                st_next.res = 9'h080;
            end
            2'h2:
            begin
                st_next.rate = 7'h2f;
                st_next.res = 9'h040;
            end
            default:
            begin
                st_next.rate = 7'h5f;
                st_next.res = 9'h020;
            end
        endcase
        case (c[`SDC_GAIN_MSB:`SDC_GAIN_LSB])
            2'h0: st_next.gain = 7'h19;
            2'h1: st_next.gain = 7'h32;
            2'h2: st_next.gain = 7'h4b;
            default: st_next.gain = 7'h64;
        endcase
        st_next.thr = thr_da(c[`SDC_THR_MSB:`SDC_THR_LSB]);
        st_next.gap = gap_ns(c[`SDC_GAP_MSB:`SDC_GAP_LSB]);
        // Start-up: sense when a threshold is set, else align and go
        case (st_reg.state)
            sdc_pkg::SDC_IDLE:
            begin
                if (START)
                begin
                    if (st_reg.cfg[`SDC_THR_MSB:`SDC_THR_LSB] == 4'h0)
                    begin
                        st_next.state = sdc_pkg::SDC_ALIGN;
                        st_next.cnt = `SDC_ALIGN_CYCLES;
                    end
                    else
                    begin
                        st_next.state = sdc_pkg::SDC_SENSE;
                    end
                end
            end
            sdc_pkg::SDC_SENSE:
            begin
                // Sensing itself lives elsewhere; one cycle marks it here
                st_next.state = sdc_pkg::SDC_RUN;
            end
            sdc_pkg::SDC_ALIGN:
            begin
                if (st_reg.cnt <= 16'h0001)
                begin
                    st_next.state = sdc_pkg::SDC_RUN;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt - 16'h0001;
                end
            end
            default:
            begin
                if (!START)
                begin
                    st_next.state = sdc_pkg::SDC_IDLE;
                end
            end
        endcase
        st_next.sense = (st_next.state == sdc_pkg::SDC_SENSE);
        st_next.align = (st_next.state == sdc_pkg::SDC_ALIGN);
    end

    // Register the state; reset clears cfg and the sequencer and loads the code-zero decodes
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_reg <= '0;
            st_reg.cfg <= `SDC_CFG_RESET;
            st_reg.adv <= 7'h1e;
            st_reg.thr <= 6'h00;
            st_reg.rate <= 7'h0c;
            st_reg.res <= 9'h100;
            st_reg.gain <= 7'h19;
            st_reg.gap <= 11'h028;
            st_reg.state <= sdc_pkg::SDC_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // Driver gap timer, length in clock cycles rounded up
    // ------------------------------------------------------------------------
    sdc_gap_timer u_gap (
        .clk(CLK),
        .rst(RST),
        .start(GAP_REQ),
        .len(11'((st_reg.gap + 11'(`SDC_CLK_NS - 1)) / 11'(`SDC_CLK_NS))),
        .busy(gap_busy)
    );

    // Outputs straight from flip-flops
    assign RDATA = st_reg.rdata;
    assign ADVANCE_DEG = st_reg.adv;
    assign THRESH_DA = st_reg.thr;
    assign SENSE_RATE_HZ = st_reg.rate;
    assign SENSE_RES_NS10 = st_reg.res;
    assign GAIN_PCT = st_reg.gain;
    assign GAP_NS = st_reg.gap;
    assign SENSE_EN = st_reg.sense;
    assign ALIGN_ACTIVE = st_reg.align;
    assign GAP_ACTIVE = gap_busy;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    rsvd_zero_a: assert property (@(posedge CLK) disable iff (RST) !st_reg.cfg[`SDC_RSVD_BIT])
        else $error("reserved bit set");
    readback_a: assert property (@(posedge CLK) disable iff (RST)
        (WR_EN && ADDR == `SDC_CFG_ADDR) ##1 (RD_EN && ADDR == `SDC_CFG_ADDR && !WR_EN)
        |=> RDATA == ($past(WDATA, 2) & 16'hff7f))
        else $error("readback mismatch");
    angle_map_a: assert property (@(posedge CLK) disable iff (RST)
        ##1 ADVANCE_DEG == 7'(({5'h00, st_reg.cfg[15:14]} + 7'h01) * 7'h1e))
        else $error("advance angle wrong");
    gap_map_a: assert property (@(posedge CLK) disable iff (RST)
        ##1 GAP_NS == 11'((11'(st_reg.cfg[4:0]) + 11'h001) * 11'h028))
        else $error("gap time wrong");
    gain_map_a: assert property (@(posedge CLK) disable iff (RST)
        ##1 GAIN_PCT == 7'(({5'h00, st_reg.cfg[6:5]} + 7'h01) * 7'h19))
        else $error("gain wrong");
    thr_one_a: assert property (@(posedge CLK) disable iff (RST)
        st_reg.cfg[13:10] == 4'h1 |-> THRESH_DA == 6'h04)
        else $error("threshold one wrong");
    res_map_a: assert property (@(posedge CLK) disable iff (RST)
        ##1 SENSE_RES_NS10 == 9'(9'h100 >> st_reg.cfg[9:8]))
        else $error("resolution wrong");
    rate_slow_a: assert property (@(posedge CLK) disable iff (RST)
        st_reg.cfg[9:8] == 2'h0 |-> SENSE_RATE_HZ == 7'h0c)
        else $error("rate wrong");
    skip_sense_a: assert property (@(posedge CLK) disable iff (RST)
        st_reg.state == sdc_pkg::SDC_IDLE && START && st_reg.cfg[13:10] == 4'h0
        |=> ALIGN_ACTIVE && !SENSE_EN)
        else $error("sensing not skipped");
    reset_clear_a: assert property (@(posedge CLK) RST |=> st_reg.cfg == 16'h0000)
        else $error("reset did not clear");

endmodule : sdc_config

// File: test/sdc_host_model.sv
// Host model: drives the register port of the configuration block.
// Assumes fixed-latency reads and writes, inputs moved 2 ns after CLK rises.
`timescale 1ns/1ps
`include "sdc_regs.svh"

module sdc_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] addr,
    output logic wr_en,
    output logic rd_en,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    // Set only by a scenario that pokes the reserved bit on purpose
    logic rsvd_poke;

    // ------------------------------------------------------------------------
    // Idle bus from time zero
    // ------------------------------------------------------------------------
    initial
    begin
        rsvd_poke = 1'b0;
        addr = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 16'h0000;
    end

    // ------------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------------
    // One-cycle write strobe; stale address and data are inverted afterwards
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #2;
        addr = a;
        wdata = rsvd_poke ? d : (d & `SDC_CFG_WMASK);
        wr_en = 1'b1;
        @(posedge clk);
        #2;
        wr_en = 1'b0;
        addr = ~addr;
        wdata = ~wdata;
    endtask : write_reg

    // Read data is registered at the strobe edge and taken just after it
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        #2;
        addr = a;
        rd_en = 1'b1;
        @(posedge clk);
        #2;
        rd_en = 1'b0;
        addr = ~addr;
        d = rdata;
    endtask : read_reg

    // Write, then read on the very next edge: back-to-back access
    task automatic write_read(input logic [7:0] a, input logic [15:0] dw, output logic [15:0] dr);
        @(posedge clk);
        #2;
        addr = a;
        wdata = dw & `SDC_CFG_WMASK;
        wr_en = 1'b1;
        @(posedge clk);
        #2;
        wr_en = 1'b0;
        rd_en = 1'b1;
        wdata = ~wdata;
        @(posedge clk);
        #2;
        rd_en = 1'b0;
        addr = ~addr;
        dr = rdata;
    endtask : write_read
endmodule : sdc_host_model

// File: test/tb.sv
// Testbench: register sweep, decode checks, start-up and gap timing.
// Assumes the host model drives the register port; 40 MHz clock.
`timescale 1ns/1ps
`include "sdc_regs.svh"

module tb;
    logic clk, rst, wr_en, rd_en, start, gap_req, sense_en, align_active, gap_active;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, d, v;
    logic [6:0] advance_deg, sense_rate_hz, gain_pct;
    logic [5:0] thresh_da;
    logic [8:0] sense_res_ns10;
    logic [10:0] gap_ns;
    int err_total, n_tests, n;

    // ------------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------------
    // Free-running 25 ns clock
    always #12.5 clk = ~clk;

    sdc_config dut (.CLK(clk), .RST(rst), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
        .WDATA(wdata), .RDATA(rdata), .START(start), .GAP_REQ(gap_req),
        .ADVANCE_DEG(advance_deg), .THRESH_DA(thresh_da), .SENSE_RATE_HZ(sense_rate_hz),
        .SENSE_RES_NS10(sense_res_ns10), .GAIN_PCT(gain_pct), .GAP_NS(gap_ns),
        .SENSE_EN(sense_en), .ALIGN_ACTIVE(align_active), .GAP_ACTIVE(gap_active));

    sdc_host_model host (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .wdata(wdata), .rdata(rdata));

    // ------------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Expected decodes worked out from the field values
    task automatic chk_dec(input logic [15:0] c);
        logic [15:0] rate;
        logic [15:0] thr;
        rate = (c[9:8] == 2'h0) ? 16'h000c : (c[9:8] == 2'h1) ? 16'h0018 : (c[9:8] == 2'h2) ? 16'h002f : 16'h005f;
        thr = (c[13:10] == 4'h0) ? 16'h0000 : (c[13:10] == 4'h1) ? 16'h0004 : {11'h0, c[13:10], 1'b0} + 16'h0002;
        chk("advance", {9'h0, advance_deg}, 16'h001e * ({14'h0, c[15:14]} + 16'h0001));
        chk("threshold", {10'h0, thresh_da}, thr);
        chk("rate", {9'h0, sense_rate_hz}, rate);
        chk("resolution", {7'h0, sense_res_ns10}, 16'h0100 >> c[9:8]);
        chk("gain", {9'h0, gain_pct}, 16'h0019 * ({14'h0, c[6:5]} + 16'h0001));
        chk("gap", {5'h0, gap_ns}, 16'h0028 * ({11'h0, c[4:0]} + 16'h0001));
    endtask : chk_dec

    // Start-up request with the threshold already programmed
    task automatic startup(input logic align);
        @(posedge clk);
        #2;
        start = 1'b1;
        @(posedge clk);
        #2;
        chk("sense flag", {15'h0, sense_en}, {15'h0, ~align});
        n = 0;
        while (align_active === 1'b1 && n < 100)
        begin
            n++;
            @(posedge clk);
            #2;
        end
        chk("align length", 16'(n), align ? `SDC_ALIGN_CYCLES : 16'h0000);
        start = 1'b0;
        repeat (3) @(posedge clk);
    endtask : startup

    // One gap request; length counted in whole clock cycles
    task automatic gap(input int c);
        host.write_reg(`SDC_CFG_ADDR, 16'(c));
        @(posedge clk);
        #2;
        gap_req = 1'b1;
        @(posedge clk);
        #2;
        gap_req = 1'b0;
        n = 0;
        while (gap_active === 1'b1 && n < 100)
        begin
            n++;
            @(posedge clk);
            #2;
        end
        chk("gap cycles", 16'(n), 16'((40 * (c + 1) + 24) / 25));
    endtask : gap

    // Verdict and end of run
    task automatic end_of_test;
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    // Reset, field sweep, refused writes, start-up and gap timing
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        start = 1'b0;
        gap_req = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (20) @(posedge clk);
        #2;
        rst = 1'b0;
        host.read_reg(`SDC_CFG_ADDR, d);
        chk("cfg reset", d, `SDC_CFG_RESET);
        chk_dec(16'h0000);
        // Bit 7 is set on purpose to see it refused
        host.rsvd_poke = 1'b1;
        for (int i = 0; i < 32; i++)
        begin
            v = {i[1:0], i[3:0], i[2:1], 1'b1, i[4:3], i[4:0]};
            host.write_reg(`SDC_CFG_ADDR, v);
            chk_dec(v & 16'hff7f);
            host.read_reg(`SDC_CFG_ADDR, d);
            chk("cfg readback", d, v & 16'hff7f);
            chk("reserved bit", {15'h0, d[7]}, 16'h0000);
        end
        host.rsvd_poke = 1'b0;
        // Neighbouring address neither writes nor reads the register
        host.write_reg(8'h97, 16'hffff);
        host.read_reg(`SDC_CFG_ADDR, d);
        chk("cfg after stray", d, v & 16'hff7f);
        host.read_reg(8'h97, d);
        chk("stray read", d, 16'h0000);
        host.write_read(`SDC_CFG_ADDR, 16'h5a5a, d);
        chk("back to back", d, 16'h5a5a);
        host.write_reg(`SDC_CFG_ADDR, 16'h0000);
        startup(1'b1);
        host.write_reg(`SDC_CFG_ADDR, 16'h0400);
        startup(1'b0);
        gap(0);
        gap(31);
        end_of_test();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #(25 * 20000);
        err_total++;
        end_of_test();
    end
endmodule : tb
